/* File: core/phymg_pkg.sv */
//------------------------------------------------------------------------------
// Function
// - With 1000BASE-T forced by strap, writes to locked management registers are refused until unlocked.
// - After the three-step unlock completes, every management write is accepted.
// - In forced 1000BASE-T mode the interrupt status register is flagged unreliable.
// - In forced 1000BASE-T mode status-extension 2 and the three error counters are flagged invalid; the code drives only o_err_cnt_valid for this.
// - In RMII mode the receive error counter at register 19 survives reads and software reset.
// - In other MAC modes register 19 clears on read and on software reset.
// - While the low-power hold pin is high the link LED may stay lit until the cable is unplugged.
// - In RGMII mode carrier sense, carrier extend and carrier extend error codes are never sent.
//------------------------------------------------------------------------------
package phymg_pkg;

    localparam int          ADDR_W       = 5;
    localparam int          DATA_W       = 16;
    localparam int          PIN_SYNC_N   = 3;

    localparam logic [4:0]  REG_CTRL     = 5'h00;
    localparam logic [4:0]  REG_GCTRL    = 5'h09;
    localparam logic [4:0]  REG_RXERR    = 5'h13;
    localparam logic [4:0]  REG_PAGE     = 5'h1F;

    localparam int          SOFT_RST_BIT = 15;
    localparam logic [15:0] UNLOCK_PAGE  = 16'h0000;
    localparam logic [15:0] GCTRL_LOCK_M = 16'hE000;
    localparam logic [15:0] RXERR_RST    = 16'h0000;
    localparam logic [15:0] RXERR_MAX    = 16'hFFFF;

    // receive codes carried with dv low and er high, and the idle data sent with both low
    localparam logic [7:0]  RX_FALSE_CAR = 8'h0E;
    localparam logic [7:0]  RX_CAR_EXT   = 8'h0F;
    localparam logic [7:0]  RX_CAR_EXTER = 8'h1F;
    localparam logic [7:0]  RX_IDLE_DATA = 8'h00;

    typedef enum logic [1:0]
    {
        MAC_GMII  = 2'h0,
        MAC_RGMII = 2'h1,
        MAC_MII   = 2'h2,
        MAC_RMII  = 2'h3
    } phymg_mac_mode_t;

    typedef struct packed
    {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } phymg_req_t;

    typedef struct packed
    {
        logic       dv;
        logic       er;
        logic [7:0] data;
    } phymg_rx_t;

endpackage

/* File: core/phymg_regmem.sv */
`timescale 1ns/1ps
`default_nettype none
module phymg_regmem
(
    input  wire logic                          i_clk,    // core clock
    input  wire logic                          i_we,     // write strobe
    input  wire logic                          i_re,     // read strobe
    input  wire logic [phymg_pkg::ADDR_W-1:0]  i_addr,   // register index
    input  wire logic [phymg_pkg::DATA_W-1:0]  i_wdata,  // write data
    output logic      [phymg_pkg::DATA_W-1:0]  o_rdata   // registered read
);

    logic [phymg_pkg::DATA_W-1:0] mem [0:(1<<phymg_pkg::ADDR_W)-1];

    always_ff @(posedge i_clk)
    begin
        if (i_we)
            mem[i_addr] <= i_wdata;
        if (i_re)
            o_rdata <= mem[i_addr];
    end

endmodule // phymg_regmem
`default_nettype wire

/* File: core/phymg_errata.sv */
`timescale 1ns/1ps
`default_nettype none
module phymg_errata
(
    input  wire logic                         i_clk,             // 200 MHz
    input  wire logic                         i_reset_n,         // hw reset pin
    input  wire logic                         i_strap_force_1g,  // strap pin
    input  wire logic                         i_low_power_hold,  // hold pin
    input  wire logic                         i_cable_present,   // media pin
    input  wire phymg_pkg::phymg_mac_mode_t   i_mac_mode,        // mac mode
    input  wire logic                         i_mgmt_valid,      // request
    input  wire phymg_pkg::phymg_req_t        i_mgmt_req,        // request body
    output logic                              o_mgmt_ack,        // answer pulse
    output logic                              o_mgmt_refused,    // write dropped
    output logic      [phymg_pkg::DATA_W-1:0] o_mgmt_rdata,      // read data
    input  wire logic                         i_link_up,         // pcs link
    input  wire logic                         i_rx_err_evt,      // rx error
    input  wire logic                         i_carrier,         // carrier seen
    input  wire phymg_pkg::phymg_rx_t         i_rx,              // pcs rx
    output phymg_pkg::phymg_rx_t              o_rx,              // mac rx
    output logic                              o_mac_crs,         // mac crs
    output logic                              o_led_link,        // link led
    output logic                              o_forced_1g,       // strap seen
    output logic                              o_int_stat_valid,  // int trusted
    output logic                              o_err_cnt_valid    // cnt trusted
);

    //--------------------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------------------
    localparam int NPIN = 3;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_reg;
    logic [NPIN-1:0] pin_s2_reg;
    logic [NPIN-1:0] pin_s3_reg;
    logic [NPIN-1:0] pin_reg;

    assign pin_raw = {i_cable_present, i_low_power_hold, i_strap_force_1g};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++)
        begin : g_pin
            always_ff @(posedge i_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    pin_s1_reg[g] <= 1'b0;
                    pin_s2_reg[g] <= 1'b0;
                    pin_s3_reg[g] <= 1'b0;
                    pin_reg[g]    <= 1'b0;
                end
                else
                begin
                    pin_s1_reg[g] <= pin_raw[g];
                    pin_s2_reg[g] <= pin_s1_reg[g];
                    pin_s3_reg[g] <= pin_s2_reg[g];
                    if (pin_s2_reg[g] == pin_s3_reg[g])
                        pin_reg[g] <= pin_s3_reg[g];
                end
            end
        end
    endgenerate

    wire strap_pin = pin_reg[0];
    wire hold_pin  = pin_reg[1];
    wire cable_pin = pin_reg[2];

    //--------------------------------------------------------------------------
    // strap capture after reset release
    //--------------------------------------------------------------------------
    logic [2:0] strap_cnt_reg;
    logic       strap_done_reg;
    logic       forced_reg;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            strap_cnt_reg  <= 3'h0;
            strap_done_reg <= 1'b0;
            forced_reg     <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            strap_cnt_reg <= strap_cnt_reg + 3'h1;
            if (strap_cnt_reg == 3'(phymg_pkg::PIN_SYNC_N + 1))
            begin
                strap_done_reg <= 1'b1;
                forced_reg     <= strap_pin;
            end
        end
    end

    //--------------------------------------------------------------------------
    // request decode
    //--------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_LOCKED,
        ST_PAGE0,
        ST_READ9,
        ST_OPEN
    } phymg_lock_t;

    phymg_lock_t lock_reg;
    phymg_lock_t lock_next;

    wire req_go   = i_mgmt_valid && strap_done_reg;
    wire is_wr    = req_go && i_mgmt_req.wr;
    wire is_rd    = req_go && !i_mgmt_req.wr;
    wire a_page   = i_mgmt_req.addr == phymg_pkg::REG_PAGE;
    wire a_gctrl  = i_mgmt_req.addr == phymg_pkg::REG_GCTRL;
    wire a_rxerr  = i_mgmt_req.addr == phymg_pkg::REG_RXERR;
    wire a_ctrl   = i_mgmt_req.addr == phymg_pkg::REG_CTRL;
    wire page_ok  = i_mgmt_req.wdata == phymg_pkg::UNLOCK_PAGE;
    wire lock_clr = (i_mgmt_req.wdata & phymg_pkg::GCTRL_LOCK_M) == 16'h0000;
    // registers 31 and 9 stay writable so the unlock itself can run
    wire wr_ok    = (lock_reg == ST_OPEN) || !forced_reg
                    || a_page || a_gctrl;
    wire wr_go    = is_wr && wr_ok;
    wire wr_drop  = is_wr && !wr_ok;
    wire rmii     = i_mac_mode == phymg_pkg::MAC_RMII;
    wire soft_rst = wr_go && a_ctrl
                    && i_mgmt_req.wdata[phymg_pkg::SOFT_RST_BIT];

    //--------------------------------------------------------------------------
    // unlock sequence
    //--------------------------------------------------------------------------
    always_comb
    begin
        lock_next = lock_reg;
        unique case (lock_reg)
            ST_LOCKED:
                if (is_wr && a_page && page_ok)
                    lock_next = ST_PAGE0;
            ST_PAGE0:
                if (is_rd && a_gctrl)
                    lock_next = ST_READ9;
                else if (is_wr && !(a_page && page_ok))
                    lock_next = ST_LOCKED;
            ST_READ9:
                if (is_wr && a_gctrl && lock_clr)
                    lock_next = ST_OPEN;
                else if (is_wr)
                    lock_next = ST_LOCKED;
            ST_OPEN:
                lock_next = ST_OPEN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            lock_reg <= ST_LOCKED;
        else if (strap_done_reg && !forced_reg)
            lock_reg <= ST_OPEN;
        else
            lock_reg <= lock_next;
    end

    //--------------------------------------------------------------------------
    // register store and receive error counter
    //--------------------------------------------------------------------------
    logic [15:0] mem_rdata;
    logic [15:0] rxerr_reg;
    logic [15:0] rxerr_snap_reg;
    logic        sel_rxerr_reg;
    logic        ack_reg;
    logic        refused_reg;

    phymg_regmem u_regmem
    (
        .i_clk   (i_clk),
        .i_we    (wr_go && !a_rxerr),
        .i_re    (is_rd),
        .i_addr  (i_mgmt_req.addr),
        .i_wdata (i_mgmt_req.wdata),
        .o_rdata (mem_rdata)
    );

    wire rxerr_rd  = is_rd && a_rxerr;
    // rmii keeps the count; only the reset pin clears it
    wire rxerr_clr = !rmii && (rxerr_rd || soft_rst);
    wire rxerr_inc = i_rx_err_evt && (rxerr_reg != phymg_pkg::RXERR_MAX);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rxerr_reg <= phymg_pkg::RXERR_RST;
        else if (rxerr_clr)
            rxerr_reg <= rxerr_inc ? 16'h0001 : phymg_pkg::RXERR_RST;
        else if (rxerr_inc)
            rxerr_reg <= rxerr_reg + 16'h0001;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rxerr_snap_reg <= 16'h0000;
            sel_rxerr_reg  <= 1'b0;
            ack_reg        <= 1'b0;
            refused_reg    <= 1'b0;
        end
        else
        begin
            if (rxerr_rd)
                rxerr_snap_reg <= rxerr_reg;
            sel_rxerr_reg <= rxerr_rd;
            ack_reg       <= req_go;
            refused_reg   <= wr_drop;
        end
    end

    assign o_mgmt_ack     = ack_reg;
    assign o_mgmt_refused = refused_reg;
    assign o_mgmt_rdata   = sel_rxerr_reg ? rxerr_snap_reg : mem_rdata;

    //--------------------------------------------------------------------------
    // status validity, led and mac receive path
    //--------------------------------------------------------------------------
    logic                 led_reg;
    logic                 crs_reg;
    phymg_pkg::phymg_rx_t rx_reg;

    wire rgmii    = i_mac_mode == phymg_pkg::MAC_RGMII;
    wire rx_side  = !i_rx.dv && i_rx.er;
    wire rx_omit  = rgmii && rx_side
                    && (i_rx.data == phymg_pkg::RX_CAR_EXT
                        || i_rx.data == phymg_pkg::RX_CAR_EXTER
                        || i_rx.data == phymg_pkg::RX_FALSE_CAR);
    // with hold high, the led drops only on cable removal
    wire led_next = i_link_up
                    || (hold_pin && led_reg && cable_pin);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            led_reg <= 1'b0;
            crs_reg <= 1'b0;
            rx_reg  <= '0;
        end
        else
        begin
            led_reg <= led_next;
            crs_reg <= i_carrier && !rgmii;
            rx_reg  <= rx_omit
                       ? phymg_pkg::phymg_rx_t'{1'b0, 1'b0,
                                               phymg_pkg::RX_IDLE_DATA}
                       : i_rx;
        end
    end

    assign o_led_link       = led_reg;
    assign o_mac_crs        = crs_reg;
    assign o_rx             = rx_reg;
    assign o_forced_1g      = forced_reg;
    assign o_int_stat_valid = strap_done_reg && !forced_reg;
    assign o_err_cnt_valid  = strap_done_reg && !forced_reg;

endmodule // phymg_errata
`default_nettype wire

/* File: tb/phymg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module phymg_checker
(
    input wire logic                       i_clk,            // clock
    input wire logic                       i_reset_n,        // reset
    input wire phymg_pkg::phymg_mac_mode_t i_mac_mode,       // mode
    input wire logic                       i_mgmt_valid,     // request
    input wire phymg_pkg::phymg_req_t      i_mgmt_req,       // body
    input wire logic                       o_mgmt_ack,       // answer
    input wire logic                       o_mgmt_refused,   // dropped
    input wire logic                       i_link_up,        // link
    input wire logic                       i_carrier,        // carrier
    input wire phymg_pkg::phymg_rx_t       i_rx,             // pcs rx
    input wire phymg_pkg::phymg_rx_t       o_rx,             // mac rx
    input wire logic                       o_mac_crs,        // crs
    input wire logic                       o_led_link,       // led
    input wire logic                       o_forced_1g,      // strap
    input wire logic                       o_int_stat_valid, // int ok
    input wire logic                       o_err_cnt_valid   // cnt ok
);
    logic car_code;
    assign car_code = i_mac_mode == phymg_pkg::MAC_RGMII && !i_rx.dv
        && i_rx.er && i_rx.data inside {phymg_pkg::RX_FALSE_CAR,
        phymg_pkg::RX_CAR_EXT, phymg_pkg::RX_CAR_EXTER};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence open_take_s;
        i_mgmt_valid && i_mgmt_req.wr && o_int_stat_valid;
    endsequence

    refused_cause_a: assert property (o_mgmt_refused |-> o_mgmt_ack
        && $past(i_mgmt_valid && i_mgmt_req.wr && o_forced_1g)
        && $past(i_mgmt_req.addr) != phymg_pkg::REG_PAGE
        && $past(i_mgmt_req.addr) != phymg_pkg::REG_GCTRL)
        else $error("refusal without locked write");
    open_write_a: assert property (open_take_s |=>
        o_mgmt_ack && !o_mgmt_refused)
        else $error("open write not accepted");
    flags_forced_a: assert property (o_forced_1g |->
        !o_int_stat_valid && !o_err_cnt_valid)
        else $error("status trusted while forced");
    rx_pass_a: assert property ($past(i_reset_n, 2)
        && $past(i_mac_mode) != phymg_pkg::MAC_RGMII
        |-> o_rx == $past(i_rx) && o_mac_crs == $past(i_carrier))
        else $error("rx or crs not passed on");
    carrier_drop_a: assert property ($past(i_reset_n, 2)
        && $past(car_code) |-> o_rx == 10'h000)
        else $error("carrier code reached mac");
    crs_rgmii_a: assert property ($past(i_mac_mode) ==
        phymg_pkg::MAC_RGMII |-> !o_mac_crs)
        else $error("crs shown in rgmii");
    led_link_a: assert property ($past(i_reset_n, 2)
        && $past(i_link_up) |-> o_led_link)
        else $error("led dark with link");
    led_off_a: assert property (!$past(i_link_up)
        && !$past(o_led_link) |-> !o_led_link)
        else $error("led lit from nothing");
endmodule // phymg_checker

bind phymg_errata phymg_checker u_chk
(
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_mac_mode(i_mac_mode),
    .i_mgmt_valid(i_mgmt_valid), .i_mgmt_req(i_mgmt_req),
    .o_mgmt_ack(o_mgmt_ack), .o_mgmt_refused(o_mgmt_refused),
    .i_link_up(i_link_up), .i_carrier(i_carrier), .i_rx(i_rx),
    .o_rx(o_rx), .o_mac_crs(o_mac_crs), .o_led_link(o_led_link),
    .o_forced_1g(o_forced_1g), .o_int_stat_valid(o_int_stat_valid),
    .o_err_cnt_valid(o_err_cnt_valid)
);
`default_nettype wire

/* File: tb/phymg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module phymg_host
(
    input  wire logic                  i_clk,     // clock
    input  wire logic                  i_ack,     // answer
    input  wire logic                  i_refused, // dropped
    input  wire logic [15:0]           i_rdata,   // read data
    output logic                       o_valid,   // request
    output phymg_pkg::phymg_req_t      o_req      // body
);
    // no led polling, no eee, no half duplex
    initial
    begin
        o_valid = 1'b0;
        o_req   = '0;
    end

    task automatic xfer(input logic wr, input logic [4:0] addr,
        input logic [15:0] wd, output logic ok, output logic rf,
        output logic [15:0] rd);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_req   = '{wr, addr, wd};
        @(negedge i_clk);
        o_valid = 1'b0;
        o_req   = ~o_req;
        ok      = i_ack;
        rf      = i_refused;
        rd      = i_rdata;
    endtask

    task automatic unlock(output logic ok);
        logic        a;
        logic        r;
        logic [15:0] d;
        xfer(1'b1, phymg_pkg::REG_PAGE, phymg_pkg::UNLOCK_PAGE, a, r, d);
        xfer(1'b0, phymg_pkg::REG_GCTRL, 16'h0000, a, r, d);
        d = d & ~phymg_pkg::GCTRL_LOCK_M;
        xfer(1'b1, phymg_pkg::REG_GCTRL, d, ok, r, d);
        ok = ok & !r;
    endtask
endmodule // phymg_host
`default_nettype wire

/* File: tb/phymg_errata_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module phymg_errata_tb;
    typedef struct packed
    {
        logic [1:0] mode;
        logic       car;
        logic [9:0] rx;
        logic       drop;
    } phymg_row_t;

    logic clk, reset_n, strap, hold, cable, valid, ack, refused;
    logic link_up, evt, carrier, crs, led, forced, int_v, err_v, ok, rf;
    logic [15:0] rdata, d;
    phymg_pkg::phymg_mac_mode_t mode;
    phymg_pkg::phymg_req_t      req;
    phymg_pkg::phymg_rx_t       rx, rx_out;
    int error_cnt, samples_checked, cycles;
    phymg_row_t rows [7] = '{'{2'h0, 1'b1, 10'h10E, 1'b0},
        '{2'h1, 1'b1, 10'h10E, 1'b1}, '{2'h1, 1'b1, 10'h10F, 1'b1},
        '{2'h1, 1'b1, 10'h11F, 1'b1}, '{2'h1, 1'b0, 10'h255, 1'b0},
        '{2'h3, 1'b1, 10'h10F, 1'b0}, '{2'h2, 1'b0, 10'h3AA, 1'b0}};

    phymg_errata u_dut
    (
        .i_clk(clk), .i_reset_n(reset_n), .i_strap_force_1g(strap),
        .i_low_power_hold(hold), .i_cable_present(cable),
        .i_mac_mode(mode), .i_mgmt_valid(valid), .i_mgmt_req(req),
        .o_mgmt_ack(ack), .o_mgmt_refused(refused),
        .o_mgmt_rdata(rdata), .i_link_up(link_up), .i_rx_err_evt(evt),
        .i_carrier(carrier), .i_rx(rx), .o_rx(rx_out), .o_mac_crs(crs),
        .o_led_link(led), .o_forced_1g(forced),
        .o_int_stat_valid(int_v), .o_err_cnt_valid(err_v)
    );

    phymg_host u_host
    (
        .i_clk(clk), .i_ack(ack), .i_refused(refused),
        .i_rdata(rdata), .o_valid(valid), .o_req(req)
    );

    always #2.5 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            $display("Error %0t: timeout", $time);
            finish_test();
        end
    end

    task automatic chk(input logic c, input string what);
        samples_checked++;
        if (c !== 1'b1)
        begin
            error_cnt++;
            $display("Error %0t: %s", $time, what);
        end
    endtask

    task automatic do_reset(input logic s);
        @(negedge clk);
        reset_n = 1'b0;
        strap   = s;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    task automatic rw(input logic wr, input logic [4:0] a,
        input logic [15:0] wd);
        u_host.xfer(wr, a, wd, ok, rf, d);
        chk(ok === 1'b1, "no ack");
    endtask

    task automatic errs(input int n);
        @(negedge clk);
        evt = 1'b1;
        repeat (n) @(negedge clk);
        evt = 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    initial
    begin
        {clk, strap, hold, cable, link_up, evt, carrier} = '0;
        reset_n = 1'b0;
        mode    = phymg_pkg::MAC_GMII;
        rx      = '0;
        do_reset(1'b0);
        // rx pass, rgmii carrier code drop and crs cases
        foreach (rows[i])
        begin
            @(negedge clk);
            mode    = phymg_pkg::phymg_mac_mode_t'(rows[i].mode);
            carrier = rows[i].car;
            rx      = rows[i].rx;
            @(negedge clk);
            chk(rx_out === (rows[i].drop ? 10'h000 : rows[i].rx), "rx");
            chk(crs === (rows[i].car && rows[i].mode != 2'h1), "crs");
        end
        // -------------------------------
        // strap forced: lock and unlock
        // -------------------------------
        do_reset(1'b1);
        chk(forced === 1'b1 && int_v === 1'b0 && err_v === 1'b0, "flags");
        rw(1'b1, 5'h05, 16'h1234);
        chk(rf === 1'b1, "locked write taken");
        u_host.unlock(ok);
        chk(ok === 1'b1, "unlock");
        rw(1'b1, 5'h05, 16'h1234);
        chk(rf === 1'b0, "open write refused");
        rw(1'b0, 5'h05, 16'h0000);
        chk(d === 16'h1234, "readback");
        // -------------------------------
        // receive error counter
        // -------------------------------
        do_reset(1'b0);
        chk(int_v === 1'b1 && err_v === 1'b1, "flags open");
        errs(3);
        rw(1'b0, phymg_pkg::REG_RXERR, 16'h0000);
        chk(d === 16'h0003, "count");
        rw(1'b0, phymg_pkg::REG_RXERR, 16'h0000);
        chk(d === 16'h0000, "clear on read");
        errs(2);
        rw(1'b1, phymg_pkg::REG_CTRL, 16'h8000);
        rw(1'b0, phymg_pkg::REG_RXERR, 16'h0000);
        chk(d === 16'h0000, "clear on soft reset");
        mode = phymg_pkg::MAC_RMII;
        errs(2);
        repeat (2)
        begin
            rw(1'b0, phymg_pkg::REG_RXERR, 16'h0000);
            chk(d === 16'h0002, "rmii read kept");
        end
        rw(1'b1, phymg_pkg::REG_CTRL, 16'h8000);
        rw(1'b0, phymg_pkg::REG_RXERR, 16'h0000);
        chk(d === 16'h0002, "rmii soft kept");
        do_reset(1'b0);
        rw(1'b0, phymg_pkg::REG_RXERR, 16'h0000);
        chk(d === 16'h0000, "hw reset clear");
        // -------------------------------
        // link led with hold pin
        // -------------------------------
        {link_up, cable} = 2'b11;
        wait_n(2);
        chk(led === 1'b1, "led on");
        link_up = 1'b0;
        wait_n(2);
        chk(led === 1'b0, "led off without hold");
        link_up = 1'b1;
        hold    = 1'b1;
        wait_n(6);
        link_up = 1'b0;
        wait_n(3);
        chk(led === 1'b1, "led held");
        cable = 1'b0;
        wait_n(8);
        chk(led === 1'b0, "led unplug");
        hold = 1'b0;
        wait_n(2);
        finish_test();
    end
endmodule // phymg_errata_tb
`default_nettype wire
